// ### adc_seq_consts.vh
// Constants for the ADC conversion-sequence controller: register map, fields, timing.
// Included by adc_sequence_control.v; definitions only.
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

`define OFF_CTL2       8'h00
`define OFF_CTL3       8'h04
`define OFF_CTL4       8'h08
`define OFF_CTL5       8'h0c
`define OFF_STATUS     8'h10
`define OFF_IRQMASK    8'h14
`define OFF_TEST       8'h18
`define OFF_RESULT0    8'h20
`define RESULT_SHIFT   2
// adc_control_2
`define C2_JUSTIFY     0
`define C2_SIGNED      1
`define C2_HALTWAIT    2
`define C2_RESET       8'h00
// adc_control_3
`define C3_SINGLE      0
`define C3_FIFO        1
`define C3_RESET       8'h00
// adc_control_4: sample time in clocks minus one
`define C4_RESET       8'h0b
// adc_control_5
`define C5_CH_LO       0
`define C5_REF         3
`define C5_SEQLEN      4
`define C5_MULT        5
`define C5_SCAN        6
`define C5_RESET       8'h00
// Status / mask bits
`define ST_SCF         0
`define ST_ABORT       1
`define ST_W           2
// Test register
`define TEST_RST       8
// Sequence lengths
`define LEN_ONE        4'd1
`define LEN_FOUR       4'd4
`define LEN_EIGHT      4'd8
`define NUM_CH         8
`define SAR_W          10
// Bit count loaded into the 4-bit APPROX_REGISTER step counter
`define SAR_W_CNT      4'd10
`define DATA_W         32
`endif

// ### adc_sequence_control.v
// Conversion-sequence controller for an eight-channel multiplexed APPROX_REGISTER converter,
// with an AXI4-Lite slave for its control, status, test and result registers.
// Assumes analog comparator is outside: cmpHigh is its decision for the trial in sarTrial.
// Behaviour
// [RULE1] Eight analog inputs are multiplexed into one successive-approximation engine.
// [RULE2] In a multi-channel sequence the three channel-select bits pick the first channel and channels step up.
// [RULE3] With the reference-select bit set internal references are converted instead of external inputs.
// [RULE4] Writing control register four aborts a running sequence and starts a new one at once.
// [RULE5] Writing control registers two or three leaves a running sequence untouched. Here a control register three write changes its length and result placement.
// [RULE6] Writing control register five aborts, clears status flags and starts a new sequence.
// [RULE7] In scan mode the sequence-complete flag is set at the end of every sequence.
// [RULE8] Reading the test register returns the live approximation register.
// [RULE9] Writing the test register reset bit resets the converter logic.
// [RULE10] Signed result, justification, single-conversion and FIFO result placement are offered.
// [RULE11] The justify bit lives in control register two and resets to the legacy format.
// [RULE12] FIFO and single-conversion bits live in control register three and reset to legacy behaviour.
// [RULE13] The sequence-length bit works as before and single-conversion overrides it.
// [RULE14] Software must not rely on control writes aborting, and must handle stray completions.
// [RULE15] Software should neither read nor write the test register in normal use.
// [RULE16] In scan mode the sequence restarts after each completion until software replaces it.
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

module adc_sequence_control (
  input  wire        ref_clk,     // System clock, 20 MHz
  input  wire        rst,         // Synchronous reset, active high
  input  wire [7:0]  s_axi_awaddr,  // Write address
  input  wire        s_axi_awvalid, // Write address valid
  output wire        s_axi_awready, // Write address ready
  input  wire [31:0] s_axi_wdata,   // Write data
  input  wire [3:0]  s_axi_wstrb,   // Write byte strobes
  input  wire        s_axi_wvalid,  // Write data valid
  output wire        s_axi_wready,  // Write data ready
  output reg  [1:0]  s_axi_bresp,   // Write response
  output reg         s_axi_bvalid,  // Write response valid
  input  wire        s_axi_bready,  // Write response ready
  input  wire [7:0]  s_axi_araddr,  // Read address
  input  wire        s_axi_arvalid, // Read address valid
  output wire        s_axi_arready, // Read address ready
  output reg  [31:0] s_axi_rdata,   // Read data
  output reg  [1:0]  s_axi_rresp,   // Read response
  output reg         s_axi_rvalid,  // Read data valid
  input  wire        s_axi_rready,  // Read data ready
  output reg  [2:0]  muxSel,      // Analog input select
  output reg         refSel,      // Converting internal reference
  output reg         sampling,    // Sample phase of a conversion
  output reg  [9:0]  sarTrial,    // Trial word to the DAC
  input  wire        cmpHigh,     // Comparator: input above trial
  output wire        irq          // Level interrupt
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SAMP = 3'b010;
  localparam ST_CONV = 3'b100;

  reg  [7:0]  ctl2, ctl3, ctl4, ctl5;
  reg  [2:0]  status, irqMask;
  reg  [2:0]  state;
  reg  [7:0]  tick;
  reg  [3:0]  bitIdx;
  reg  [9:0]  approxRegister;
  reg  [3:0]  convCount;
  reg  [2:0]  fifoPtr;
  reg  [9:0]  results [0:`NUM_CH-1];
  reg  [7:0]  awAddr;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  reg         awHeld, wHeld;
  reg  [2:0]  firstCh;

  wire wrFire = awHeld && wHeld && !s_axi_bvalid;
  wire wrCtl2 = wrFire && awAddr == `OFF_CTL2 && wStrb[0];
  wire wrCtl3 = wrFire && awAddr == `OFF_CTL3 && wStrb[0];
  wire wrCtl4 = wrFire && awAddr == `OFF_CTL4 && wStrb[0];
  wire wrCtl5 = wrFire && awAddr == `OFF_CTL5 && wStrb[0];
  wire wrStat = wrFire && awAddr == `OFF_STATUS && wStrb[0];
  wire wrMask = wrFire && awAddr == `OFF_IRQMASK && wStrb[0];
  wire wrTest = wrFire && awAddr == `OFF_TEST && wStrb[1];
  wire testRst = wrTest && wData[`TEST_RST];  // RULE9
  wire restart = wrCtl4 || wrCtl5;             // RULE4
  wire multiCh = ctl5[`C5_MULT];
  wire scanOn  = ctl5[`C5_SCAN];

  // Single-conversion overrides the legacy length bit
  wire [3:0] seqLen = ctl3[`C3_SINGLE] ? `LEN_ONE :
                      (ctl5[`C5_SEQLEN] ? `LEN_EIGHT : `LEN_FOUR);  // RULE13

  wire seqDone = state == ST_CONV && bitIdx == 4'd0 && tick == 8'h00 && convCount == seqLen - 4'd1;
  wire convDone = state == ST_CONV && bitIdx == 4'd0 && tick == 8'h00;

  assign s_axi_awready = !awHeld;
  assign s_axi_wready  = !wHeld;
  assign s_axi_arready = !s_axi_rvalid;
  assign irq = |(status & irqMask);

  // Write channel: address and data taken in either order
  always @(posedge ref_clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr <= `OFF_TEST && awAddr[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers; writes to two and three never restart the sequencer
  always @(posedge ref_clk) begin
    if (rst) begin
      ctl2 <= `C2_RESET;  // RULE11
      ctl3 <= `C3_RESET;  // RULE12
      ctl4 <= `C4_RESET;
      ctl5 <= `C5_RESET;
      irqMask <= 3'b000;
    end else begin
      if (wrCtl2) ctl2 <= wData[7:0];  // RULE5
      if (wrCtl3) ctl3 <= wData[7:0];  // RULE5
      if (wrCtl4) ctl4 <= wData[7:0];
      if (wrCtl5) ctl5 <= wData[7:0];
      if (wrMask) irqMask <= wData[2:0];
    end
  end

  // Status: hardware set beats software clear
  always @(posedge ref_clk) begin
    if (rst || testRst) begin
      status <= 3'b000;
    end else begin
      if (wrCtl5) status <= 3'b000;  // RULE6
      else if (wrStat) status <= status & ~wData[2:0];
      if (seqDone && !restart) status[`ST_SCF] <= 1'b1;  // RULE7
      if (restart && state != ST_IDLE) status[`ST_ABORT] <= 1'b1;
    end
  end

  // Sequencer: one APPROX_REGISTER engine shared by all channels
  always @(posedge ref_clk) begin
    if (rst || testRst) begin  // RULE9
      state <= ST_IDLE;
      tick <= 8'h00;
      bitIdx <= 4'd0;
      approxRegister <= 10'h000;
      convCount <= 4'd0;
      fifoPtr <= 3'd0;
      firstCh <= 3'd0;
      muxSel <= 3'd0;
      refSel <= 1'b0;
      sampling <= 1'b0;
      sarTrial <= 10'h000;
    end else if (restart) begin  // RULE4
      state <= ST_SAMP;
      tick <= ctl4;
      convCount <= 4'd0;
      if (wrCtl5) begin
        firstCh <= wData[`C5_CH_LO+2:`C5_CH_LO];  // RULE2
        muxSel <= wData[`C5_CH_LO+2:`C5_CH_LO];
        refSel <= wData[`C5_REF];  // RULE3
        fifoPtr <= 3'd0;
      end else begin
        muxSel <= firstCh;
      end
      if (wrCtl4) tick <= wData[7:0];
      sampling <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          sampling <= 1'b0;
        end
        ST_SAMP: begin
          if (tick == 8'h00) begin
            state <= ST_CONV;
            sampling <= 1'b0;
            bitIdx <= `SAR_W_CNT;
            approxRegister <= 10'h000;
            sarTrial <= 10'h200;
            tick <= 8'h00;
          end else begin
            tick <= tick - 8'h01;
          end
        end
        ST_CONV: begin  // RULE1
          if (bitIdx != 4'd0) begin
            approxRegister[bitIdx-4'd1] <= cmpHigh;
            bitIdx <= bitIdx - 4'd1;
            if (bitIdx > 4'd1)
              sarTrial <= (approxRegister | ({9'h000, cmpHigh} << (bitIdx - 4'd1))) |
                          (10'h001 << (bitIdx - 4'd2));
          end else begin
            results[ctl3[`C3_FIFO] ? fifoPtr : (multiCh ? convCount[2:0] : 3'd0)] <= approxRegister;  // RULE10
            fifoPtr <= fifoPtr + 3'd1;
            if (convDone && convCount != seqLen - 4'd1) begin
              convCount <= convCount + 4'd1;
              if (multiCh) muxSel <= muxSel + 3'd1;  // RULE2
              state <= ST_SAMP;
              tick <= ctl4;
              sampling <= 1'b1;
            end else if (scanOn) begin  // RULE16
              convCount <= 4'd0;
              muxSel <= firstCh;
              state <= ST_SAMP;
              tick <= ctl4;
              sampling <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Result formatting: justification and signed option
  function [31:0] fmtResult;
    input [9:0] raw;
    input       justify;
    input       signedOut;
    reg   [9:0] v;
    begin
      v = signedOut ? {~raw[9], raw[8:0]} : raw;
      if (justify)
        fmtResult = {22'h000000, v};  // RULE10
      else
        fmtResult = {16'h0000, v, 6'h00};
    end
  endfunction

  wire [7:0] rdAddr = s_axi_araddr;
  wire [2:0] rdIdx  = rdAddr[`RESULT_SHIFT+2:`RESULT_SHIFT];

  always @(posedge ref_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (rdAddr >= `OFF_RESULT0 && rdAddr < `OFF_RESULT0 + 8'h20 && rdAddr[1:0] == 2'b00) begin
        s_axi_rdata <= fmtResult(results[rdIdx], ctl2[`C2_JUSTIFY], ctl2[`C2_SIGNED]);
      end else begin
        case (rdAddr)
          `OFF_CTL2:    s_axi_rdata <= {24'h000000, ctl2};
          `OFF_CTL3:    s_axi_rdata <= {24'h000000, ctl3};
          `OFF_CTL4:    s_axi_rdata <= {24'h000000, ctl4};
          `OFF_CTL5:    s_axi_rdata <= {24'h000000, ctl5};
          `OFF_STATUS:  s_axi_rdata <= {28'h0000000, state != ST_IDLE, status};
          `OFF_IRQMASK: s_axi_rdata <= {29'h00000000, irqMask};
          `OFF_TEST:    s_axi_rdata <= {22'h000000, approxRegister};  // RULE8
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### adc_sequence_control_checker.sv
// Checker for adc_sequence_control: bus handshakes, restarts, test read.
// Sees only the top module ports; bound at the foot of this file.
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module adc_sequence_control_checker (
  input wire logic       ref_clk,       // Clock
  input wire logic       rst,           // Reset
  input wire logic [7:0] s_axi_awaddr,  // Write addr
  input wire logic       s_axi_awvalid, // AW valid
  input wire logic       s_axi_awready, // AW ready
  input wire logic       s_axi_bvalid,  // B valid
  input wire logic       s_axi_bready,  // B ready
  input wire logic [7:0] s_axi_araddr,  // Read addr
  input wire logic       s_axi_arvalid, // AR valid
  input wire logic       s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata,  // Read data
  input wire logic       s_axi_rvalid,  // R valid
  input wire logic       s_axi_rready,  // R ready
  input wire logic       sampling,      // Sample phase
  input wire logic [9:0] sarTrial,      // Trial word
  input wire logic       irq            // Interrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] lastAw;
  // Address is gone by the time bvalid rises, so keep it
  always @(posedge ref_clk) if (s_axi_awvalid && s_axi_awready) lastAw <= s_axi_awaddr;
  property p_rstIdle; $fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !sampling; endproperty
  a_rstIdle: assert property (p_rstIdle) else $error("not idle after reset");
  property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rHold: assert property (p_rHold) else $error("read data dropped");
  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bHold: assert property (p_bHold) else $error("write response dropped");
  property p_arBlock; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arBlock: assert property (p_arBlock) else $error("read taken while busy");
  property p_rLat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rLat: assert property (p_rLat) else $error("read answer late");
  property p_restart4; $rose(s_axi_bvalid) && lastAw == `OFF_CTL4 |-> ##[0:2] sampling; endproperty
  a_restart4: assert property (p_restart4) else $error("no restart on ctl4");
  property p_restart5; $rose(s_axi_bvalid) && lastAw == `OFF_CTL5 |-> ##[0:2] sampling; endproperty
  a_restart5: assert property (p_restart5) else $error("no restart on ctl5");
  // While sampling, the last trial word matches the approximation register above bit 0
  property p_testRd; s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFF_TEST && sampling
    |=> s_axi_rdata[31:10] == 22'h000000 && s_axi_rdata[9:1] == $past(sarTrial[9:1]); endproperty
  a_testRd: assert property (p_testRd) else $error("test read not approx");
endmodule
bind adc_sequence_control adc_sequence_control_checker u_adc_sequence_control_checker (.ref_clk, .rst,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sampling, .sarTrial, .irq);

// ### adc_sequence_control_tb_top.sv
// Testbench for adc_sequence_control: AXI4-Lite master tasks, one task per scenario.
// Assumes the checker is compiled alongside; comparator input toggles each cycle.
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module adc_sequence_control_tb_top;
  logic        ref_clk = 0, rst = 1, cmpHigh = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, got;
  logic [3:0]  wstrb = 0;
  logic        awready, wready, arready, bvalid, rvalid, refSel, sampling, irq;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  muxSel;
  logic [9:0]  sarTrial;
  int          errors = 0, comparisons = 0, cyc = 0;
  adc_sequence_control u_adc_sequence_control (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .muxSel(muxSel), .refSel(refSel), .sampling(sampling), .sarTrial(sarTrial), .cmpHigh(cmpHigh), .irq(irq));
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cmpHigh <= ~cmpHigh;
    cyc <= cyc + 1;
    // Whole run needs about a thousand cycles
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Each channel is released at the rising edge that takes it
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic waitIrq();
    do @(negedge ref_clk); while (irq !== 1'b1);
  endtask
  task automatic seq(input logic [31:0] c5, input int n);
    wr(`OFF_CTL5, c5);
    chk(irq, 0);
    repeat (n) @(negedge sampling);
    repeat (14) @(negedge ref_clk);
    chk({irq, sampling}, 2'b10);
  endtask
  task automatic t_reset();
    rd(`OFF_CTL2);
    chk(got, `C2_RESET);
    rd(`OFF_CTL3);
    chk(got, `C3_RESET);
    rd(`OFF_CTL4);
    chk(got, `C4_RESET);
    rd(8'h1c);
    chk(resp, 2'b10);
    wr(8'h40, 32'h1);
    chk(resp, 2'b10);
    wr(`OFF_IRQMASK, 32'h1);
    rd(`OFF_IRQMASK);
    chk(got, 32'h1);
  endtask
  task automatic t_length();
    seq(32'h20, 4);
    seq(32'h30, 8);
    wr(`OFF_CTL3, 32'h1);
    seq(32'h30, 1);
    wr(`OFF_CTL3, 32'h0);
  endtask
  task automatic t_channel();
    wr(`OFF_CTL5, 32'h27);
    chk(muxSel, 7);
    @(negedge sampling);
    do @(negedge ref_clk); while (sampling !== 1'b1);
    chk(muxSel, 0);
    waitIrq();
    wr(`OFF_CTL5, 32'h08);
    chk(refSel, 1);
    waitIrq();
  endtask
  task automatic t_abort();
    wr(`OFF_CTL5, 32'h24);
    @(negedge sampling);
    do @(negedge ref_clk); while (sampling !== 1'b1);
    wr(`OFF_CTL2, 32'h0);
    chk(muxSel, 5);
    wr(`OFF_CTL4, `C4_RESET);
    chk(muxSel, 4);
    waitIrq();
  endtask
  task automatic t_scan();
    wr(`OFF_CTL5, 32'h40);
    waitIrq();
    wr(`OFF_STATUS, 32'h1);
    chk(irq, 0);
    waitIrq();
    chk(irq, 1);
    wr(`OFF_CTL5, 32'h0);
    waitIrq();
  endtask
  task automatic t_testRst();
    wr(`OFF_CTL5, 32'h20);
    rd(`OFF_TEST);
    chk(got[31:10], 0);
    wr(`OFF_TEST, 32'h100, 4'h2);
    repeat (30) @(negedge ref_clk);
    chk({irq, sampling}, 2'b00);
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_length();
    t_channel();
    t_abort();
    t_scan();
    // Test register is touched only in this last scenario
    t_testRst();
    tally_and_finish();
  end
endmodule
